// [clock_startup_pkg.sv]
// Constants and types shared by the clock source and start-up logic
package clock_startup_pkg;

    // ==========================================================
    // Clock source select fuse codes
    localparam logic [1:0] SRC_EXTERNAL = 2'h0;
    localparam logic [1:0] SRC_RESERVED = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h2;
    localparam logic [1:0] SRC_LOW_FREQ = 2'h3;

    // ==========================================================
    // Start-up time fuse codes
    localparam logic [1:0] SUT_NO_TIMEOUT = 2'h0;
    localparam logic [1:0] SUT_SHORT_TIMEOUT = 2'h1;
    localparam logic [1:0] SUT_LONG_TIMEOUT = 2'h2;
    localparam logic [1:0] SUT_RESERVED = 2'h3;

    // A fuse bit at zero is programmed, at one unprogrammed
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // ==========================================================
    // Start-up cycle counts and time-out lengths
    localparam logic [4:0] STARTUP_CK_FROM_RESET = 5'h0E;
    localparam logic [4:0] STARTUP_CK_FROM_WAKE = 5'h06;
    localparam int TIMEOUT_SHORT_WDT_CYCLES = 4096;
    localparam int TIMEOUT_LONG_WDT_CYCLES = 8192;

    // ==========================================================
    // Prescaler select reset values and limit
    localparam logic [3:0] PRESCALE_UNDIVIDED = 4'h0;
    localparam logic [3:0] PRESCALE_DIV8 = 4'h3;
    localparam logic [3:0] PRESCALE_MAX = 4'h8;
    localparam int PRESCALE_COUNT_W = 8;

    // ==========================================================
    // Sleep mode codes from the sleep controller
    localparam logic [1:0] SLEEP_IDLE = 2'h0;
    localparam logic [1:0] SLEEP_CONV_QUIET = 2'h1;
    localparam logic [1:0] SLEEP_POWER_DOWN = 2'h2;

    localparam int TRIM_W = 8;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;

    typedef enum logic [2:0] {
        ST_FUSE_LOAD,
        ST_TIMEOUT,
        ST_STARTUP,
        ST_RUN,
        ST_POWER_DOWN
    } startup_state_t;

endpackage : clock_startup_pkg

// [osc_tick_if.sv]
// Interface carrying one oscillator level and its synchronised edge pulse
`timescale 1ns/1ps
`default_nettype none
interface osc_tick_if;
    logic level;
    logic pulse;

    modport sync_side (input level, output pulse);
    modport user_side (output level, input pulse);
endinterface : osc_tick_if
`default_nettype wire

// [osc_edge_sync.sv]
// Two-flop synchroniser and rising-edge detector for an oscillator level
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    osc_tick_if.sync_side tick
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // ==========================================================
    // Synchroniser chain; sync_reg and last_reg feed the edge detector
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= tick.level;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per oscillator cycle; source must be below half of clk_in
    assign tick.pulse = sync_reg & ~last_reg;

endmodule : osc_edge_sync
`default_nettype wire

// [clock_source_startup_control.sv]
// Clock source selection, start-up reset sequencing and clock domain gating
//
// Summary of operation
// - Two-bit source fuses: 00 external, 01 reserved, 10 internal, 11 low.
// - A fuse bit at one is unprogrammed, at zero programmed.
// - Default fuses: internal oscillator, start-up 10, divide by eight.
// - Internal reset stays asserted for a time-out after other resets.
// - Time-out in watchdog cycles: 0, 4096, 8192; code 11 reserved.
// - A counter of selected-source cycles holds reset, then releases it.
// - Reset applies time-out plus start-up; wake applies start-up only.
// - Factory trim value loads into the trim register during reset.
// - Software may rewrite the trim register to retune the oscillator.
// - Time-out and watchdog always run from the watchdog oscillator.
// - Start-up is 6 cycles from power-down, 14 cycles from reset.
// - Reset pin disabled with start-up 00 lengthens to short time-out, except on the external clock.
// - Source code 11 makes the low-frequency oscillator the clock.
// - Core clock stops execution; peripheral clock feeds timers and ports.
// - Two-wire start detection and async wake work in every sleep mode; here wake_event_in acts only from power-down.
// - Sleep modes stop the clocks of unused domains.
// - Flash interface clock runs whenever the core clock runs.
// - Converter clock keeps running while core and peripheral stop.
// - Fast two-wire clock carries the undivided source clock.
// - Programmed divide-by-eight fuse gives one eighth system clock.
// - Prescaler loads 0000, or 0011 when divide-by-eight is programmed.
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_control
    import clock_startup_pkg::*;
#(
    parameter int TIMEOUT_SHORT_CYCLES = TIMEOUT_SHORT_WDT_CYCLES,
    parameter int TIMEOUT_LONG_CYCLES = TIMEOUT_LONG_WDT_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic other_reset_active_in,
    input wire logic [1:0] clock_source_select_fuses_in,
    input wire logic [1:0] startup_time_fuses_in,
    input wire logic divide_by_eight_fuse_in,
    input wire logic reset_pin_disable_fuse_in,
    input wire logic [TRIM_W-1:0] factory_trim_in,
    input wire logic external_clock_in,
    input wire logic internal_osc_in,
    input wire logic low_freq_osc_in,
    input wire logic watchdog_osc_in,
    input wire logic wake_event_in,
    input wire logic sleep_request_in,
    input wire logic [1:0] sleep_mode_in,
    input wire logic trim_write_in,
    input wire logic [TRIM_W-1:0] trim_data_in,
    output logic internal_reset_out,
    output logic config_fault_out,
    output logic [1:0] active_source_out,
    output logic [TRIM_W-1:0] oscillator_trim_register_out,
    output logic [3:0] prescaler_select_field_out,
    output logic core_clock_out,
    output logic peripheral_clock_out,
    output logic flash_interface_clock_out,
    output logic converter_clock_out,
    output logic fast_two_wire_clock_out,
    output logic watchdog_clock_out,
    output logic two_wire_start_watch_out
);
    localparam int COUNT_W = $clog2(TIMEOUT_LONG_CYCLES + 1);
    localparam int FUSE_W = 6 + TRIM_W;

    // ==========================================================
    // Oscillator edge synchronisers
    osc_tick_if ext_tick ();
    osc_tick_if int_tick ();
    osc_tick_if low_tick ();
    osc_tick_if wdt_tick ();

    assign ext_tick.level = external_clock_in;
    assign int_tick.level = internal_osc_in;
    assign low_tick.level = low_freq_osc_in;
    assign wdt_tick.level = watchdog_osc_in;

    osc_edge_sync ext_sync (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .tick(ext_tick));
    osc_edge_sync int_sync (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .tick(int_tick));
    osc_edge_sync low_sync (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .tick(low_tick));
    osc_edge_sync wdt_sync (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .tick(wdt_tick));

    // ==========================================================
    // Pin synchronisers for fuses, reset sources and wake
    logic [FUSE_W-1:0] fuse_meta_reg;
    logic [FUSE_W-1:0] fuse_sync_reg;
    logic [1:0] async_meta_reg;
    logic [1:0] async_sync_reg;
    logic reset_src;
    logic wake_src;

    // Fuses reset to the shipped default, so a floating read is safe
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            fuse_meta_reg <= {SRC_INTERNAL, SUT_LONG_TIMEOUT,
                FUSE_PROGRAMMED, ~FUSE_PROGRAMMED, TRIM_RESET};
            fuse_sync_reg <= {SRC_INTERNAL, SUT_LONG_TIMEOUT,
                FUSE_PROGRAMMED, ~FUSE_PROGRAMMED, TRIM_RESET};
            async_meta_reg <= 2'h1;
            async_sync_reg <= 2'h1;
        end
        else
        begin
            fuse_meta_reg <= {clock_source_select_fuses_in,
                startup_time_fuses_in, divide_by_eight_fuse_in,
                reset_pin_disable_fuse_in, factory_trim_in};
            fuse_sync_reg <= fuse_meta_reg;
            async_meta_reg <= {wake_event_in, other_reset_active_in};
            async_sync_reg <= async_meta_reg;
        end
    end

    assign reset_src = async_sync_reg[0];
    assign wake_src = async_sync_reg[1];

    // ==========================================================
    // Fuse capture, held while running
    logic [1:0] src_fuse_reg;
    logic [1:0] sut_fuse_reg;
    logic div8_fuse_reg;
    logic rstdis_fuse_reg;
    startup_state_t state_reg;
    startup_state_t state_next;

    // Capture only while internal reset is in its first phase
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            src_fuse_reg <= SRC_INTERNAL;
            sut_fuse_reg <= SUT_LONG_TIMEOUT;
            div8_fuse_reg <= FUSE_PROGRAMMED;
            rstdis_fuse_reg <= ~FUSE_PROGRAMMED;
        end
        else if (state_reg == ST_FUSE_LOAD)
        begin
            src_fuse_reg <= fuse_sync_reg[FUSE_W-1 -: 2];
            sut_fuse_reg <= fuse_sync_reg[FUSE_W-3 -: 2];
            div8_fuse_reg <= fuse_sync_reg[TRIM_W+1];
            rstdis_fuse_reg <= fuse_sync_reg[TRIM_W];
        end
    end

    // ==========================================================
    // Decode; reserved codes fall back to the shipped default
    logic [1:0] eff_src;
    logic [1:0] eff_sut;
    logic div8_programmed;
    logic rstdis_programmed;
    logic src_pulse;
    logic [COUNT_W-1:0] timeout_load;

    assign eff_src = (src_fuse_reg == SRC_RESERVED) ? SRC_INTERNAL
        : src_fuse_reg;
    assign eff_sut = (sut_fuse_reg == SUT_RESERVED) ? SUT_LONG_TIMEOUT
        : sut_fuse_reg;
    assign div8_programmed = (div8_fuse_reg == FUSE_PROGRAMMED);
    assign rstdis_programmed = (rstdis_fuse_reg == FUSE_PROGRAMMED);

    // Selected oscillator edge drives start-up and the divider
    always_comb
    begin
        case (eff_src)
            SRC_EXTERNAL: src_pulse = ext_tick.pulse;
            SRC_LOW_FREQ: src_pulse = low_tick.pulse;
            default: src_pulse = int_tick.pulse;
        endcase
    end

    // Time-out length in watchdog cycles for this start-up code
    always_comb
    begin
        case (eff_sut)
            SUT_NO_TIMEOUT:
            begin
                // Keeps a window to enter programming without a reset pin
                if (rstdis_programmed && eff_src != SRC_EXTERNAL)
                    timeout_load = COUNT_W'(TIMEOUT_SHORT_CYCLES);
                else
                    timeout_load = '0;
            end
            SUT_SHORT_TIMEOUT:
                timeout_load = COUNT_W'(TIMEOUT_SHORT_CYCLES);
            default:
                timeout_load = COUNT_W'(TIMEOUT_LONG_CYCLES);
        endcase
    end

    // ==========================================================
    // Start-up sequencer
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic count_last;
    logic timeout_pulse;

    // Time-out always counts watchdog edges, whatever the source
    assign timeout_pulse = wdt_tick.pulse;
    assign count_last = (count_reg == COUNT_W'(1));

    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_FUSE_LOAD:
            begin
                if (!reset_src)
                begin
                    if (timeout_load == '0)
                    begin
                        state_next = ST_STARTUP;
                        count_next = COUNT_W'(STARTUP_CK_FROM_RESET);
                    end
                    else
                    begin
                        state_next = ST_TIMEOUT;
                        count_next = timeout_load;
                    end
                end
            end
            ST_TIMEOUT:
            begin
                if (timeout_pulse && count_last)
                begin
                    state_next = ST_STARTUP;
                    count_next = COUNT_W'(STARTUP_CK_FROM_RESET);
                end
                else if (timeout_pulse)
                    count_next = count_reg - COUNT_W'(1);
            end
            ST_STARTUP:
            begin
                if (src_pulse && count_last)
                    state_next = ST_RUN;
                else if (src_pulse)
                    count_next = count_reg - COUNT_W'(1);
            end
            ST_RUN:
            begin
                if (sleep_request_in && sleep_mode_in == SLEEP_POWER_DOWN)
                    state_next = ST_POWER_DOWN;
            end
            ST_POWER_DOWN:
            begin
                if (wake_src)
                begin
                    state_next = ST_STARTUP;
                    count_next = COUNT_W'(STARTUP_CK_FROM_WAKE);
                end
            end
            default:
                state_next = ST_FUSE_LOAD;
        endcase
        if (reset_src)
        begin
            state_next = ST_FUSE_LOAD;
            count_next = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_FUSE_LOAD;
            count_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Internal reset follows the next state so release is not a cycle late
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            internal_reset_out <= 1'b1;
        else
            internal_reset_out <= !(state_next == ST_RUN ||
                state_next == ST_POWER_DOWN);
    end

    // ==========================================================
    // Trim register and prescaler select
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            oscillator_trim_register_out <= TRIM_RESET;
        else if (state_reg == ST_FUSE_LOAD)
            oscillator_trim_register_out <= fuse_sync_reg[TRIM_W-1:0];
        else if (trim_write_in && state_reg == ST_RUN)
            oscillator_trim_register_out <= trim_data_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            prescaler_select_field_out <= PRESCALE_DIV8;
        else if (state_reg == ST_FUSE_LOAD)
            prescaler_select_field_out <= div8_programmed ? PRESCALE_DIV8
                : PRESCALE_UNDIVIDED;
    end

    // ==========================================================
    // System clock divider on selected-source edges
    logic [PRESCALE_COUNT_W-1:0] div_reg;
    logic [PRESCALE_COUNT_W-1:0] div_limit;
    logic [3:0] shift_amt;
    logic sys_pulse;

    // Settings above the table limit clamp rather than wrap
    assign shift_amt = (prescaler_select_field_out > PRESCALE_MAX)
        ? PRESCALE_MAX : prescaler_select_field_out;
    assign div_limit = PRESCALE_COUNT_W'((9'h001 << shift_amt) - 9'h001);
    assign sys_pulse = src_pulse && (div_reg >= div_limit);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            div_reg <= '0;
        else if (sys_pulse)
            div_reg <= '0;
        else if (src_pulse)
            div_reg <= div_reg + PRESCALE_COUNT_W'(1);
    end

    // ==========================================================
    // Domain enables per sleep mode
    logic running;
    logic core_on;
    logic periph_on;
    logic conv_on;

    assign running = (state_reg == ST_RUN);
    assign core_on = running && !sleep_request_in;
    assign periph_on = running && (!sleep_request_in ||
        sleep_mode_in == SLEEP_IDLE);
    assign conv_on = running && (!sleep_request_in ||
        sleep_mode_in == SLEEP_IDLE ||
        sleep_mode_in == SLEEP_CONV_QUIET);

    // Clock outputs are one-cycle enables; registered to avoid glitches
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            core_clock_out <= 1'b0;
            peripheral_clock_out <= 1'b0;
            flash_interface_clock_out <= 1'b0;
            converter_clock_out <= 1'b0;
            fast_two_wire_clock_out <= 1'b0;
            watchdog_clock_out <= 1'b0;
            two_wire_start_watch_out <= 1'b0;
        end
        else
        begin
            core_clock_out <= sys_pulse && core_on;
            peripheral_clock_out <= sys_pulse && periph_on;
            flash_interface_clock_out <= sys_pulse && core_on;
            converter_clock_out <= sys_pulse && conv_on;
            fast_two_wire_clock_out <= src_pulse && running;
            watchdog_clock_out <= wdt_tick.pulse;
            // Start detection needs no peripheral clock, so it stays armed
            two_wire_start_watch_out <= (state_next == ST_RUN ||
                state_next == ST_POWER_DOWN);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            config_fault_out <= 1'b0;
            active_source_out <= SRC_INTERNAL;
        end
        else
        begin
            config_fault_out <= (src_fuse_reg == SRC_RESERVED) ||
                (sut_fuse_reg == SUT_RESERVED);
            active_source_out <= eff_src;
        end
    end

    // ==========================================================
    // Assertions
    sequence wake_seen_s;
        state_reg == ST_POWER_DOWN && wake_src && !reset_src;
    endsequence

    sequence timeout_done_s;
        state_reg == ST_TIMEOUT && count_last && timeout_pulse && !reset_src;
    endsequence

    AST_NO_RESERVED_SOURCE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) running |-> eff_src != SRC_RESERVED)
        else $error("reserved source code used while running");

    AST_RESET_HELD_IN_TIMEOUT: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        state_reg == ST_TIMEOUT |=> internal_reset_out)
        else $error("internal reset dropped during time-out");

    AST_TIMEOUT_TO_STARTUP: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) timeout_done_s |=>
        state_reg == ST_STARTUP &&
        count_reg == COUNT_W'(STARTUP_CK_FROM_RESET))
        else $error("time-out did not hand over to 14 cycle start-up");

    AST_WAKE_SHORT_STARTUP: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) wake_seen_s |=>
        state_reg == ST_STARTUP &&
        count_reg == COUNT_W'(STARTUP_CK_FROM_WAKE))
        else $error("wake did not load 6 cycle start-up");

    AST_TIMEOUT_WDT_ONLY: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        state_reg == ST_TIMEOUT && !timeout_pulse && !reset_src
        |=> $stable(count_reg))
        else $error("time-out advanced without watchdog edge");

    AST_TRIM_LOAD: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) state_reg == ST_FUSE_LOAD
        |=> oscillator_trim_register_out == $past(fuse_sync_reg[TRIM_W-1:0]))
        else $error("factory trim not loaded during reset");

    AST_TRIM_WRITE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) running && trim_write_in && !reset_src
        |=> oscillator_trim_register_out == $past(trim_data_in))
        else $error("trim write ignored");

    AST_DIV8_RESET_VALUE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) state_reg == ST_STARTUP ##1 running
        |-> prescaler_select_field_out ==
        (div8_programmed ? PRESCALE_DIV8 : PRESCALE_UNDIVIDED))
        else $error("prescaler reset value wrong");

    AST_FLASH_WITH_CORE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        flash_interface_clock_out == core_clock_out)
        else $error("flash clock differs from core clock");

    AST_POWER_DOWN_QUIET: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) state_reg == ST_POWER_DOWN
        |=> !core_clock_out && !peripheral_clock_out &&
        !converter_clock_out)
        else $error("clock ran in power-down");

endmodule : clock_source_startup_control
`default_nettype wire

// [osc_sources.sv]
// Free-running behavioural oscillators feeding the clock source inputs
`timescale 1ns/1ps
`default_nettype none
module osc_sources
#(
    parameter int EXT_HALF = 101,
    parameter int INT_HALF = 83,
    parameter int LOW_HALF = 119,
    parameter int WDT_HALF = 139
)
(
    output logic ext_out,
    output logic int_out,
    output logic low_out,
    output logic wdt_out
);
    // ==========================================================
    // Oscillators
    // Odd half periods keep the edges drifting against the system clock
    initial
    begin
        ext_out = 1'b0;
        int_out = 1'b1;
        low_out = 1'b0;
        wdt_out = 1'b1;
    end
    always #(EXT_HALF) ext_out = ~ext_out;
    always #(INT_HALF) int_out = ~int_out;
    always #(LOW_HALF) low_out = ~low_out;
    // Watchdog oscillator never stops, whatever source is chosen
    always #(WDT_HALF) wdt_out = ~wdt_out;
endmodule : osc_sources
`default_nettype wire

// [tb.sv]
// Self-checking bench for clock selection and start-up sequencing
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clock_startup_pkg::*;
    typedef struct {logic [1:0] src; logic [3:0] ps; logic flt;
        logic [7:0] trim; int n; int per; int s;} note_t;
    // ==========================================================
    // Signals
    logic clk_in, rst_n_in, other_reset_active_in, div8, rdis, tw, irst;
    logic [1:0] src_f, sut_f, src_o, smode;
    logic [7:0] ftrim, tdata, trim_o;
    logic [3:0] ps_o;
    logic flt_o, core, per_clk, flash, conv, fast, wdt, tws;
    logic ext, intosc, low, wdo, slp, wk;
    logic [31:0] rnd;
    int cyc, t0, seen, errors, checked, lat, sp, nc, nf, nv, nk, nw, k;
    note_t notes[$];
    note_t nt;
    // Fuses {src, sut, div8, rdis}, expected source, time-out, fault
    logic [12:0] cases [8] = '{13'b101001_10_1000_0, 13'b000011_00_0000_0,
        13'b110111_11_0100_0, 13'b110010_11_0100_0, 13'b011011_10_1000_1,
        13'b101111_10_1000_1, 13'b000010_00_0000_0, 13'b100011_10_0000_0};
    clock_source_startup_control #(.TIMEOUT_SHORT_CYCLES(4),
        .TIMEOUT_LONG_CYCLES(8)) i_clock_source_startup_control (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .other_reset_active_in(other_reset_active_in),
        .clock_source_select_fuses_in(src_f), .startup_time_fuses_in(sut_f),
        .divide_by_eight_fuse_in(div8), .reset_pin_disable_fuse_in(rdis),
        .factory_trim_in(ftrim), .external_clock_in(ext),
        .internal_osc_in(intosc), .low_freq_osc_in(low),
        .watchdog_osc_in(wdo), .wake_event_in(wk),
        .sleep_request_in(slp), .sleep_mode_in(smode),
        .trim_write_in(tw), .trim_data_in(tdata), .internal_reset_out(irst),
        .config_fault_out(flt_o), .active_source_out(src_o),
        .oscillator_trim_register_out(trim_o),
        .prescaler_select_field_out(ps_o), .core_clock_out(core),
        .peripheral_clock_out(per_clk), .flash_interface_clock_out(flash),
        .converter_clock_out(conv), .fast_two_wire_clock_out(fast),
        .watchdog_clock_out(wdt), .two_wire_start_watch_out(tws));
    osc_sources i_osc_sources (.ext_out(ext), .int_out(intosc),
        .low_out(low), .wdt_out(wdo));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic near(input int g, input int e);
        return g >= e - 1 && g <= e + 1;
    endfunction : near
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // Start-up from an asserted outside reset with the given fuses, then a wake start-up
    task automatic run_case(input logic [12:0] c);
        @(posedge clk_in);
        #2 {other_reset_active_in, wk} = 2'b10;
        {src_f, sut_f, div8, rdis} = c[12:7];
        rnd = xs(rnd);
        ftrim = rnd[7:0];
        repeat (8) @(posedge clk_in);
        // A trim write while held in reset must not stick
        #2 tw = 1'b1;
        tdata = ~rnd[7:0];
        @(posedge clk_in);
        #2 tw = 1'b0;
        repeat (4) @(posedge clk_in);
        #2 other_reset_active_in = 1'b0;
        t0 = cyc;
        nt = '{c[6:5], c[8] ? PRESCALE_UNDIVIDED : PRESCALE_DIV8, c[0],
            rnd[7:0], int'(c[4:1]), c[6] ? (c[5] ? 238 : 166) : 202, 14};
        notes.push_back(nt);
        k = seen;
        wait (seen != k);
        // Back-to-back trim writes land one edge later each
        rnd = xs(rnd);
        @(posedge clk_in);
        #2 tw = 1'b1;
        tdata = rnd[7:0];
        @(posedge clk_in);
        #2 tdata = rnd[15:8];
        chk("trim_wr", rnd[7:0], trim_o);
        @(posedge clk_in);
        #2 tw = 1'b0;
        chk("trim_wr", rnd[15:8], trim_o);
        // Idle stops the core only; converter-quiet keeps the converter only
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk_in);
            #2 {slp, smode} = {1'b1, 2'(m)};
            {nc, nv, nk} = '0;
            repeat (400)
            begin
                @(posedge clk_in);
                #1;
                nc += int'(core === 1'b1);
                nv += int'(per_clk === 1'b1);
                nk += int'(conv === 1'b1);
            end
            lat = 8000 / (nt.per << nt.ps);
            chk("sleep_core", 0, nc);
            chk("sleep_io", m == 0, near(nv, lat));
            chk("sleep_conv", 1, near(nk, lat));
        end
        // Power-down keeps start detection armed; wake skips the time-out
        @(posedge clk_in);
        #2 smode = SLEEP_POWER_DOWN;
        repeat (100) @(posedge clk_in);
        #2 {slp, wk} = 2'b01;
        chk("pd_watch", 1, tws);
        t0 = cyc;
        nt.n = 0;
        nt.s = 6;
        nt.trim = rnd[15:8];
        notes.push_back(nt);
        k = seen;
        wait (seen != k);
        $display("case %h done", c);
    endtask : run_case
    // ==========================================================
    // Clock, cycle count and hang limit
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            stop_test();
        end
    end
    // ==========================================================
    // Watcher: each reset release takes the oldest note
    initial
    forever
    begin
        @(negedge irst);
        lat = cyc - t0;
        nt = notes.pop_front();
        sp = (nt.per + 19) / 20;
        chk("release", 1, lat >= nt.n * 14 - 16 + (nt.s - 1) * sp
            && lat <= nt.n * 14 + 20 + (nt.s + 1) * sp);
        chk("source", nt.src, src_o);
        chk("prescale", nt.ps, ps_o);
        chk("fault", nt.flt, flt_o);
        chk("trim", nt.trim, trim_o);
        {nc, nf, nv, nk, nw} = '0;
        repeat (800)
        begin
            @(posedge clk_in);
            #1;
            nc += int'(core === 1'b1);
            nf += int'(flash === 1'b1);
            nv += int'(conv === 1'b1 && per_clk === 1'b1);
            nk += int'(fast === 1'b1);
            nw += int'(wdt === 1'b1);
        end
        chk("core", 1, near(nc, 16000 / (nt.per << nt.ps)));
        chk("flash", nc, nf);
        chk("conv_io", nc, nv);
        chk("fast", 1, near(nk, 16000 / nt.per));
        chk("wdt", 1, near(nw, 16000 / 278));
        chk("start_watch", 1, tws);
        seen++;
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        {clk_in, rst_n_in, tw, tdata, cyc, seen, errors, checked} = '0;
        {src_f, sut_f, div8, rdis, ftrim} = 14'h3FFF;
        {other_reset_active_in, slp, wk, smode} = 5'h10;
        rnd = 32'd49760;
        repeat (12) @(posedge clk_in);
        #2 rst_n_in = 1'b1;
        foreach (cases[i]) run_case(cases[i]);
        stop_test();
    end
endmodule : tb
`default_nettype wire
